// ### design/adcc_pkg.sv
// adcc_pkg: register map, field positions and reset values of the
// converter control block.
// assumes a 32-bit classic wishbone slave port with byte addresses.
package adcc_pkg;
    // register byte offsets
    localparam logic [7:0] ADCC_CTRL_OFS = 8'h00;
    localparam logic [7:0] ADCC_TIME_OFS = 8'h04;
    localparam logic [7:0] ADCC_RESULT_OFS = 8'h08;
    // control register field positions
    localparam int ADCC_ON_BIT = 15;
    localparam int ADCC_STOP_IN_IDLE_BIT = 13;
    localparam int ADCC_OUTPUT_FORMAT_CODE_LSB = 8;
    localparam int ADCC_TRIG_LSB = 5;
    localparam int ADCC_STOP_AUTOSAMPLE_ON_INTERRUPT_BIT = 4;
    localparam int ADCC_AUTO_SAMPLE_ENABLE_BIT = 2;
    localparam int ADCC_SAMPLE_ACTIVE_BIT = 1;
    localparam int ADCC_DONE_BIT = 0;
    // time register field positions
    localparam int ADCC_CLKSRC_BIT = 15;
    localparam int ADCC_AUTO_SAMPLE_TIME_LSB = 8;
    // reset values
    localparam logic [31:0] ADCC_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] ADCC_TIME_RST = 32'h0000_0000;
    // output format codes
    localparam logic [2:0] ADCC_FMT_SFRAC32 = 3'h7;
    localparam logic [2:0] ADCC_FMT_FRAC32 = 3'h6;
    localparam logic [2:0] ADCC_FMT_SINT32 = 3'h5;
    localparam logic [2:0] ADCC_FMT_INT32 = 3'h4;
    localparam logic [2:0] ADCC_FMT_SFRAC16 = 3'h3;
    localparam logic [2:0] ADCC_FMT_FRAC16 = 3'h2;
    localparam logic [2:0] ADCC_FMT_INT16 = 3'h0;
    // trigger source codes
    localparam logic [2:0] ADCC_TRG_SOFT = 3'h0;
    localparam logic [2:0] ADCC_TRG_PIN = 3'h1;
    localparam logic [2:0] ADCC_TRG_TIMER = 3'h2;
    localparam logic [2:0] ADCC_TRG_CHARGE_TIME_UNIT = 3'h3;
    localparam logic [2:0] ADCC_TRG_AUTO = 3'h7;
    typedef enum logic [1:0] {
        ADCC_IDLE,
        ADCC_SAMPLE,
        ADCC_CONVERT
    } adcc_state_e;
endpackage

// ### design/adcc_control.sv
// adcc_control: sample/convert sequencing, control registers, result
// formatting, wishbone slave.
// assumes an analog core that converts on conv_start_out and answers with
// a one-cycle conv_done_in plus a 10-bit code on conv_data_in.
//
// Chosen here: the address map and the Wishbone slave port.
`timescale 1ns/1ps

module adcc_control
    import adcc_pkg::*;
#(
    parameter int DATA_W = 10
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    // wishbone slave
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    // system and trigger sources
    input wire logic system_idle_in,
    input wire logic external_interrupt_zero_in,
    input wire logic ext_int_rising_in,
    input wire logic timer3_match_in,
    input wire logic charge_time_unit_in,
    // analog core
    input wire logic conv_done_in,
    input wire logic [DATA_W-1:0] conv_data_in,
    output logic sample_out,
    output logic conv_start_out,
    output logic conv_clk_sel_out,
    output logic [31:0] result_out
);

    adcc_state_e state_q, state_d;
    logic on_q, on_d;
    logic stop_in_idle_q, stop_in_idle_d;
    logic [2:0] output_format_code_q, output_format_code_d;
    logic [2:0] trig_q, trig_d;
    logic stop_autosample_on_interrupt_q, stop_autosample_on_interrupt_d;
    logic auto_sample_enable_q, auto_sample_enable_d;
    logic sample_active_q, sample_active_d;
    logic done_q, done_d;
    logic clksrc_q, clksrc_d;
    logic [4:0] auto_sample_time_q, auto_sample_time_d;
    logic [4:0] cnt_q, cnt_d;
    logic [31:0] result_q, result_d;
    logic ack_q, ack_d;
    logic [31:0] rdat_q, rdat_d;
    logic [2:0] pin_sync_q;
    logic pin_prev_q;
    logic pin_edge;
    logic run;
    logic trig_hit;
    logic wr_ctrl, wr_time;
    logic [31:0] ctrl_word, time_word;

    // three-stage sync; edge when stages two and three agree on a change to the ext_int_rising_in level
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pin_sync_q <= 3'h0;
            pin_prev_q <= 1'b0;
        end else begin
            pin_sync_q <= {pin_sync_q[1:0], external_interrupt_zero_in};
            if (pin_sync_q[2] == pin_sync_q[1]) begin
                pin_prev_q <= pin_sync_q[2];
            end
        end
    end

    assign pin_edge = (pin_sync_q[2] == pin_sync_q[1])
        && (pin_sync_q[2] != pin_prev_q)
        && (pin_sync_q[2] == ext_int_rising_in);

    function automatic logic [31:0] fmt_result(input logic [2:0] f,
                                               input logic [9:0] d);
        logic [31:0] w;
        w = 32'h0000_0000;
        unique case (f)
            ADCC_FMT_SFRAC32, ADCC_FMT_FRAC32: w = {d, 22'h000000};
            ADCC_FMT_SINT32: w = {{22{d[9]}}, d};
            ADCC_FMT_SFRAC16, ADCC_FMT_FRAC16: w = {16'h0000, d, 6'h00};
            default: w = {22'h000000, d};
        endcase
        return w;
    endfunction

    assign ctrl_word = {16'h0000, on_q, 1'b0, stop_in_idle_q, 2'b00, output_format_code_q,
                        trig_q, stop_autosample_on_interrupt_q, 1'b0, auto_sample_enable_q, sample_active_q, done_q};
    assign time_word = {16'h0000, clksrc_q, 2'b00, auto_sample_time_q, 8'h00};
    assign wr_ctrl = wb_cyc_in && wb_stb_in && wb_we_in && !ack_q
        && (wb_adr_in == ADCC_CTRL_OFS);
    assign wr_time = wb_cyc_in && wb_stb_in && wb_we_in && !ack_q
        && (wb_adr_in == ADCC_TIME_OFS);
    assign run = on_q && !(stop_in_idle_q && system_idle_in);

    // trigger select; reserved codes never fire
    always_comb begin
        unique case (trig_q)
            ADCC_TRG_PIN: trig_hit = pin_edge;
            ADCC_TRG_TIMER: trig_hit = timer3_match_in;
            ADCC_TRG_CHARGE_TIME_UNIT: trig_hit = charge_time_unit_in;
            ADCC_TRG_AUTO: trig_hit = (cnt_q >= auto_sample_time_q);
            default: trig_hit = 1'b0;
        endcase
    end

    always_comb begin
        state_d = state_q;
        on_d = on_q;
        stop_in_idle_d = stop_in_idle_q;
        output_format_code_d = output_format_code_q;
        trig_d = trig_q;
        stop_autosample_on_interrupt_d = stop_autosample_on_interrupt_q;
        auto_sample_enable_d = auto_sample_enable_q;
        sample_active_d = sample_active_q;
        done_d = done_q;
        clksrc_d = clksrc_q;
        auto_sample_time_d = auto_sample_time_q;
        cnt_d = cnt_q;
        result_d = result_q;
        conv_start_out = 1'b0;
        ack_d = wb_cyc_in && wb_stb_in && !ack_q;
        rdat_d = 32'h0000_0000;
        if (wb_cyc_in && wb_stb_in && !wb_we_in && !ack_q) begin
            unique case (wb_adr_in)
                ADCC_CTRL_OFS: rdat_d = ctrl_word;
                ADCC_TIME_OFS: rdat_d = time_word;
                ADCC_RESULT_OFS: rdat_d = result_q;
                default: rdat_d = 32'h0000_0000;
            endcase
        end
        if (wr_ctrl && wb_sel_in[1]) begin
            on_d = wb_dat_in[ADCC_ON_BIT];
            stop_in_idle_d = wb_dat_in[ADCC_STOP_IN_IDLE_BIT];
            output_format_code_d = wb_dat_in[ADCC_OUTPUT_FORMAT_CODE_LSB +: 3];
        end
        if (wr_ctrl && wb_sel_in[0]) begin
            trig_d = wb_dat_in[ADCC_TRIG_LSB +: 3];
            stop_autosample_on_interrupt_d = wb_dat_in[ADCC_STOP_AUTOSAMPLE_ON_INTERRUPT_BIT];
            auto_sample_enable_d = wb_dat_in[ADCC_AUTO_SAMPLE_ENABLE_BIT];
            sample_active_d = wb_dat_in[ADCC_SAMPLE_ACTIVE_BIT];
            if (!wb_dat_in[ADCC_DONE_BIT]) begin
                done_d = 1'b0;
            end
        end
        if (wr_time && wb_sel_in[1]) begin
            clksrc_d = wb_dat_in[ADCC_CLKSRC_BIT];
            auto_sample_time_d = wb_dat_in[ADCC_AUTO_SAMPLE_TIME_LSB +: 5];
        end
        if (!on_q) begin
            state_d = ADCC_IDLE;
        end else if (run) begin
            unique case (state_q)
                ADCC_IDLE: begin
                    if (auto_sample_enable_q) begin
                        sample_active_d = 1'b1;
                    end
                    if (sample_active_d) begin
                        state_d = ADCC_SAMPLE;
                        cnt_d = 5'h00;
                    end
                end
                ADCC_SAMPLE: begin
                    cnt_d = cnt_q + 5'h01;
                    if (trig_q == ADCC_TRG_SOFT) begin
                        if (!sample_active_d) begin
                            state_d = ADCC_CONVERT;
                        end
                    end else if (trig_hit) begin
                        sample_active_d = 1'b0;
                        state_d = ADCC_CONVERT;
                    end
                    if (state_d == ADCC_CONVERT) begin
                        conv_start_out = 1'b1;
                        done_d = 1'b0;
                    end
                end
                ADCC_CONVERT: begin
                    if (conv_done_in) begin
                        done_d = 1'b1;
                        result_d = fmt_result(output_format_code_q, conv_data_in);
                        if (stop_autosample_on_interrupt_q) begin
                            auto_sample_enable_d = 1'b0;
                        end
                        if (auto_sample_enable_d) begin
                            sample_active_d = 1'b1;
                            state_d = ADCC_SAMPLE;
                            cnt_d = 5'h00;
                        end else begin
                            state_d = ADCC_IDLE;
                        end
                    end
                end
                default: state_d = ADCC_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_q <= ADCC_IDLE;
            on_q <= ADCC_CTRL_RST[ADCC_ON_BIT];
            stop_in_idle_q <= ADCC_CTRL_RST[ADCC_STOP_IN_IDLE_BIT];
            output_format_code_q <= ADCC_CTRL_RST[ADCC_OUTPUT_FORMAT_CODE_LSB +: 3];
            trig_q <= ADCC_CTRL_RST[ADCC_TRIG_LSB +: 3];
            stop_autosample_on_interrupt_q <= ADCC_CTRL_RST[ADCC_STOP_AUTOSAMPLE_ON_INTERRUPT_BIT];
            auto_sample_enable_q <= ADCC_CTRL_RST[ADCC_AUTO_SAMPLE_ENABLE_BIT];
            sample_active_q <= ADCC_CTRL_RST[ADCC_SAMPLE_ACTIVE_BIT];
            done_q <= ADCC_CTRL_RST[ADCC_DONE_BIT];
            clksrc_q <= ADCC_TIME_RST[ADCC_CLKSRC_BIT];
            auto_sample_time_q <= ADCC_TIME_RST[ADCC_AUTO_SAMPLE_TIME_LSB +: 5];
            cnt_q <= 5'h00;
            result_q <= 32'h0000_0000;
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            state_q <= state_d;
            on_q <= on_d;
            stop_in_idle_q <= stop_in_idle_d;
            output_format_code_q <= output_format_code_d;
            trig_q <= trig_d;
            stop_autosample_on_interrupt_q <= stop_autosample_on_interrupt_d;
            auto_sample_enable_q <= auto_sample_enable_d;
            sample_active_q <= sample_active_d;
            done_q <= done_d;
            clksrc_q <= clksrc_d;
            auto_sample_time_q <= auto_sample_time_d;
            cnt_q <= cnt_d;
            result_q <= result_d;
            ack_q <= ack_d;
            rdat_q <= rdat_d;
        end
    end

    // ack follows each strobe by one cycle; !ack_q blocks a second ack and a repeat write
    assign wb_ack_out = ack_q;
    assign wb_dat_out = rdat_q;
    assign sample_out = (state_q == ADCC_SAMPLE);
    assign conv_clk_sel_out = clksrc_q;
    assign result_out = result_q;

endmodule // adcc_control

// ### sim/adcc_core_model.sv
// adcc_core_model: behavioural analog core answering conversion starts.
// assumes one clock; code_in is the value the next conversion returns.
`timescale 1ns/1ps
module adcc_core_model (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic start_in,
    input wire logic [9:0] code_in,
    output logic done_out,
    output logic [9:0] data_out
);
    logic busy_q;
    logic [3:0] cnt_q;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            busy_q <= 1'b0;
            cnt_q <= 4'h0;
        end else if (start_in) begin
            busy_q <= 1'b1;
            cnt_q <= 4'h3;
        end else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
        end else begin
            busy_q <= 1'b0;
        end
    end
    assign done_out = busy_q && (cnt_q == 4'h0);
    // stale code is inverted so a late sample never passes
    assign data_out = done_out ? code_in : ~code_in;
endmodule // adcc_core_model

// ### sim/adcc_control_sva.sv
// adcc_control_sva: bus and sequencing checks on the control block.
// assumes it is bound to adcc_control; one clock, async low reset.
`timescale 1ns/1ps
module adcc_control_sva (
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic wb_ack_out,
    input wire logic conv_done_in,
    input wire logic sample_out,
    input wire logic conv_start_out,
    input wire logic conv_clk_sel_out,
    input wire logic [31:0] result_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!reset_n_in);
    sequence s_take;
        wb_cyc_in && wb_stb_in && !wb_ack_out;
    endsequence
    sequence s_wr;
        wb_cyc_in && wb_we_in;
    endsequence
    chk_ack_next: assert property (s_take |=> wb_ack_out)
        else $error("ack missing");
    chk_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out)
        else $error("ack longer than one cycle");
    chk_start_sampling: assert property (conv_start_out |-> sample_out)
        else $error("start outside sampling");
    chk_sample_ends: assert property (conv_start_out |=> !sample_out)
        else $error("sampling not ended");
    chk_one_start: assert property (conv_start_out |=> (!conv_start_out)[*2])
        else $error("start repeated");
    chk_result_cause: assert property ($changed(result_out) |-> $past(conv_done_in))
        else $error("result moved without done");
    chk_clk_sel_cause: assert property ($changed(conv_clk_sel_out) |->
        $past(wb_we_in && wb_stb_in) || $past(wb_we_in && wb_stb_in, 2))
        else $error("clock select moved without write");
    chk_sample_rise: assert property ($rose(sample_out) |-> $past(conv_done_in)
        || $past(wb_cyc_in && wb_we_in) || $past(wb_cyc_in && wb_we_in, 2)
        || $past(wb_cyc_in && wb_we_in, 3))
        else $error("sampling began without cause");
endmodule // adcc_control_sva
bind adcc_control adcc_control_sva i_sva (.core_clk_in, .reset_n_in,
    .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_ack_out, .conv_done_in,
    .sample_out, .conv_start_out, .conv_clk_sel_out, .result_out);

// ### sim/test_adcc_control.sv
// test_adcc_control: directed bench for the converter control block.
// assumes adcc_core_model as analog core and a 40 MHz clock.
`timescale 1ns/1ps
module test_adcc_control;
    import adcc_pkg::*;
    logic core_clk_in = 0, reset_n_in = 0, wb_cyc_in = 0, wb_stb_in = 0;
    logic wb_we_in = 0, system_idle_in = 0, external_interrupt_zero_in = 0;
    logic ext_int_rising_in = 1, timer3_match_in = 0, charge_time_unit_in = 0;
    logic conv_done_in, sample_out, conv_start_out, conv_clk_sel_out;
    logic wb_ack_out;
    logic [7:0] wb_adr_in = 0;
    logic [3:0] wb_sel_in = 4'hF;
    logic [31:0] wb_dat_in = 0, wb_dat_out, result_out, rd;
    logic [9:0] conv_data_in, code = 10'h2A5;
    int fail_count = 0, comparisons = 0, cycles = 0, starts = 0;
    always #12.5 core_clk_in = ~core_clk_in;
    adcc_control i_adcc_control (.core_clk_in, .reset_n_in, .wb_cyc_in,
        .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in,
        .wb_dat_out, .wb_ack_out, .system_idle_in,
        .external_interrupt_zero_in, .ext_int_rising_in, .timer3_match_in,
        .charge_time_unit_in, .conv_done_in, .conv_data_in, .sample_out,
        .conv_start_out, .conv_clk_sel_out, .result_out);
    adcc_core_model i_adcc_core_model (.clk_in(core_clk_in),
        .rst_n_in(reset_n_in), .start_in(conv_start_out), .code_in(code),
        .done_out(conv_done_in), .data_out(conv_data_in));
    always @(posedge core_clk_in) begin
        cycles++;
        if (conv_start_out === 1'b1)
            starts++;
        if (cycles == 20000) begin
            fail_count++;
            results();
        end
    end
    function automatic logic [31:0] ctl(input logic on, input logic [2:0] f,
        input logic [2:0] t, input logic as, input logic s);
        ctl = {16'h0, on, 4'h0, f, t, 1'b0, 1'b0, as, s, 1'b0};
    endfunction
    function automatic logic [31:0] fmt(input logic [2:0] f,
        input logic [9:0] d);
        case (f)
            3'h7, 3'h6: fmt = {d, 22'h0};
            3'h5: fmt = {{22{d[9]}}, d};
            3'h3, 3'h2: fmt = {16'h0, d, 6'h0};
            default: fmt = {22'h0, d};
        endcase
    endfunction
    task automatic wb(input logic we, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge core_clk_in);
        wb_cyc_in <= 1'b1;
        wb_stb_in <= 1'b1;
        wb_we_in <= we;
        wb_adr_in <= a;
        wb_dat_in <= d;
        do @(posedge core_clk_in); while (wb_ack_out !== 1'b1);
        rd = wb_dat_out;
        wb_cyc_in <= 1'b0;
        wb_stb_in <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wait_done();
        int n = 0;
        while (conv_done_in !== 1'b1 && n < 60) begin
            @(posedge core_clk_in);
            n++;
        end
        repeat (2) @(posedge core_clk_in);
        chk(32'(n < 60), 32'h1);
    endtask
    task automatic fire(input int s);
        @(posedge core_clk_in);
        external_interrupt_zero_in <= (s == 1);
        timer3_match_in <= (s == 2);
        charge_time_unit_in <= (s == 3);
        @(posedge core_clk_in);
        timer3_match_in <= 1'b0;
        charge_time_unit_in <= 1'b0;
        repeat (5) @(posedge core_clk_in);
        external_interrupt_zero_in <= 1'b0;
        repeat (5) @(posedge core_clk_in);
    endtask
    task automatic t_regs();
        wb(0, ADCC_CTRL_OFS, 0);
        chk(rd, ADCC_CTRL_RST);
        wb(1, ADCC_TIME_OFS, 32'h0000_8800);
        wb(0, ADCC_TIME_OFS, 0);
        chk(rd, 32'h0000_8800);
        chk(32'(conv_clk_sel_out), 32'h1);
        wb(0, 8'h3C, 0);
        chk(rd, 32'h0);
        $display("regs test done");
    endtask
    task automatic t_soft();
        logic [2:0] fl[7] = '{3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h0};
        foreach (fl[i]) begin
            code = 10'h2A5 ^ 10'(i * 37);
            wb(1, ADCC_CTRL_OFS, ctl(1, fl[i], 0, 0, 1));
            wb(1, ADCC_CTRL_OFS, ctl(1, fl[i], 0, 0, 0));
            wait_done();
            chk(result_out, fmt(fl[i], code));
            wb(0, ADCC_CTRL_OFS, 0);
            chk(rd, ctl(1, fl[i], 0, 0, 0) | 32'h1);
            wb(1, ADCC_CTRL_OFS, ctl(1, fl[i], 0, 0, 0));
            wb(0, ADCC_CTRL_OFS, 0);
            chk(rd, ctl(1, fl[i], 0, 0, 0));
        end
        $display("format test done");
    endtask
    task automatic t_trig();
        int n0;
        for (int t = 1; t <= 4; t++) begin
            wb(1, ADCC_CTRL_OFS, ctl(1, 3'h4, 3'(t), 0, 1));
            for (int s = 1; s <= 3; s++) begin
                n0 = starts;
                fire(s);
                chk(32'(starts - n0), 32'(s == t));
            end
            chk(result_out, fmt(3'h4, code));
        end
        $display("trigger test done");
    endtask
    task automatic t_auto();
        wb(1, ADCC_CTRL_OFS, ctl(1, 3'h5, 3'h7, 1, 0));
        for (int k = 0; k < 3; k++) begin
            wait_done();
            chk(32'(sample_out), 32'h1);
        end
        chk(result_out, fmt(3'h5, code));
        wb(1, ADCC_CTRL_OFS, 0);
        $display("auto test done");
    endtask
    task automatic t_off();
        int n0;
        n0 = starts;
        // wb leaves an idle cycle after clearing enable
        wb(1, ADCC_CTRL_OFS, ctl(0, 0, 0, 0, 1));
        wb(1, ADCC_CTRL_OFS, ctl(0, 0, 0, 0, 0));
        chk(32'(starts - n0), 32'h0);
        system_idle_in <= 1'b1;
        wb(1, ADCC_CTRL_OFS, ctl(1, 0, 0, 0, 1) | 32'h2000);
        wb(1, ADCC_CTRL_OFS, ctl(1, 0, 0, 0, 0) | 32'h2000);
        chk(32'(starts - n0), 32'h0);
        wb(1, ADCC_CTRL_OFS, 0);
        system_idle_in <= 1'b0;
        $display("off test done");
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge core_clk_in);
        reset_n_in <= 1'b1;
        t_regs();
        t_soft();
        t_trig();
        t_auto();
        t_off();
        results();
    end
endmodule // test_adcc_control
